// file: design/ccu_pkg.sv
// ==========================================================
// Shared constants for the capture/compare unit
package ccu_pkg;
	// ==========================================================
	// Geometry
	localparam int CCU_CH    = 16;
	localparam int CCU_TW    = 16;
	localparam int CCU_AW    = 8;
	localparam int CCU_TB_N  = 2;
	localparam int CCU_PRE_W = 5;
	localparam int CCU_SLOT_W = 3;
	localparam int CCU_STAGGER_SLOTS = 8;

	// ==========================================================
	// Byte addresses of the single registers
	localparam logic [7:0] CCU_ADDR_CTRL     = 8'h00;
	localparam logic [7:0] CCU_ADDR_RELOAD_A = 8'h04;
	localparam logic [7:0] CCU_ADDR_RELOAD_B = 8'h08;
	localparam logic [7:0] CCU_ADDR_TIMER_A  = 8'h0c;
	localparam logic [7:0] CCU_ADDR_TIMER_B  = 8'h10;
	localparam logic [7:0] CCU_ADDR_STAT     = 8'h14;
	localparam logic [7:0] CCU_ADDR_MASK     = 8'h18;
	localparam logic [7:0] CCU_ADDR_PINS     = 8'h1c;
	// Regions by address bits 7:6; channel index in bits 5:2
	localparam logic [1:0] CCU_REGION_MISC = 2'h0;
	localparam logic [1:0] CCU_REGION_CFG  = 2'h1;
	localparam logic [1:0] CCU_REGION_VAL  = 2'h2;
	localparam logic [3:0] CCU_MISC_LAST   = 4'h7;

	// ==========================================================
	// Field positions
	localparam int CCU_CTRL_RUN_LSB   = 0;
	localparam int CCU_CTRL_SEL_A_LSB = 2;
	localparam int CCU_CTRL_SEL_B_LSB = 5;
	localparam int CCU_CTRL_STAGGER   = 8;
	localparam int CCU_SEL_W          = 3;
	localparam int CCU_CFG_TB         = 0;
	localparam int CCU_CFG_FUNC_LSB   = 1;
	localparam int CCU_CFG_DOUBLE     = 4;
	localparam int CCU_CFG_SINGLE     = 5;
	localparam int CCU_CFG_W          = 6;
	localparam int CCU_STAT_OVF_LSB   = 16;
	localparam int CCU_STAT_W         = 18;
	localparam int CCU_PINS_OUT_LSB   = 16;

	// ==========================================================
	// Clock source codes and reset values
	localparam logic [2:0]  CCU_SEL_NEIGHBOUR = 3'h6;
	localparam logic [2:0]  CCU_SEL_EXT       = 3'h7;
	localparam logic [1:0]  CCU_RUN_RST       = 2'h0;
	localparam logic [2:0]  CCU_SEL_RST       = 3'h0;
	localparam logic [15:0] CCU_RELOAD_RST    = 16'h0000;
	localparam logic [15:0] CCU_TIMER_RST     = 16'h0000;
	localparam logic [15:0] CCU_VAL_RST       = 16'h0000;
	localparam logic [5:0]  CCU_CFG_RST       = 6'h00;
	localparam logic [17:0] CCU_MASK_RST      = 18'h00000;

	// Channel function field
	typedef enum logic [2:0] {
		CCU_OFF, CCU_CAP_RISE, CCU_CAP_FALL, CCU_CAP_BOTH,
		CCU_CMP_M0, CCU_CMP_M1, CCU_CMP_M2, CCU_CMP_M3
	} ccu_func_t;
endpackage : ccu_pkg

// file: design/ccu_cc_store.sv
`timescale 1ns/1ps
// ==========================================================
// Capture/compare value array, all entries visible at once
module ccu_cc_store import ccu_pkg::*; #(
	parameter int CH = CCU_CH,
	parameter int TW = CCU_TW,
	parameter int IW = $clog2(CH)
) (
	input  wire logic            i_sys_clk,
	input  wire logic            i_rstn,
	input  wire logic            i_wr_en,
	input  wire logic [IW-1:0]   i_wr_idx,
	input  wire logic [TW-1:0]   i_wr_data,
	input  wire logic [CH-1:0]   i_cap,
	input  wire logic [CH*TW-1:0] i_cap_data,
	output logic      [CH*TW-1:0] o_vals
);
	// Capture beats a software write to the same entry
	for (genvar n = 0; n < CH; n++) begin : g_ent
		always_ff @(posedge i_sys_clk) begin
			if (!i_rstn) begin
				o_vals[n*TW +: TW] <= CCU_VAL_RST;
			end else if (i_cap[n]) begin
				o_vals[n*TW +: TW] <= i_cap_data[n*TW +: TW];
			end else if (i_wr_en && i_wr_idx == IW'(n)) begin
				o_vals[n*TW +: TW] <= i_wr_data;
			end
		end
	end
endmodule : ccu_cc_store

// file: design/ccu_unit_two.sv
`timescale 1ns/1ps
// Behaviour
// - Sixteen channels; one-cycle resolution, eight cycles when staggered.
// - Two independent 16-bit timers with own reload registers as time bases.
// - Each timer clocked by prescaled system clock or neighbour timer overflow.
// - First timer may also count external count input edges.
// - Sixteen registers, each assignable to either timer, capture or compare.
// - Each register owns one pin: capture trigger or compare output.
// - Capture latches assigned timer value and raises channel interrupt.
// - Capture edge per channel: rising, falling or both.
// - Compare registers continuously matched against their timer; match runs mode.
// - Mode 0: interrupt only, several per timer period.
// - Mode 1: pin toggles every match, several per period.
// - Mode 2: interrupt only, at most one per timer period.
// - Mode 3: pin high on match, low on timer overflow, once per period.
// - Double register: two registers share one pin, toggling on either match.
// - Single event option limits any compare mode to one edge or pulse.
module ccu_unit_two import ccu_pkg::*; #(
	parameter int CH = CCU_CH,
	parameter int TW = CCU_TW
) (
	input  wire logic              i_sys_clk,
	input  wire logic              i_rstn,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [CCU_AW-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire logic [CH-1:0]     i_cc_pin,
	output logic      [CH-1:0]     o_cc_pin,
	output logic      [CH-1:0]     o_cc_pin_oe,
	input  wire logic              i_ext_count,
	input  wire logic              i_neighbour_timer_six_ovf,
	output logic                   o_irq
);
	localparam int IW = $clog2(CH);

	// ==========================================================
	// Declarations
	logic [CH-1:0]       pin_s1;
	logic [CH-1:0]       pin_s2;
	logic [CH-1:0]       pin_prev;
	logic                ext_s1;
	logic                ext_s2;
	logic                ext_prev;
	logic                ext_edge;
	logic [CH-1:0]       pin_rise;
	logic [CH-1:0]       pin_fall;
	logic                apb_setup;
	logic                wr_acc;
	logic                rd_acc;
	logic [1:0]          region;
	logic [IW-1:0]       idx;
	logic                mapped;
	logic [CCU_TB_N-1:0] tb_run;
	logic [CCU_SEL_W-1:0] tb_sel [CCU_TB_N];
	logic                stagger;
	logic [CCU_PRE_W-1:0] pre;
	logic [CCU_SLOT_W-1:0] slot;
	logic [TW-1:0]       tb_val [CCU_TB_N];
	logic [TW-1:0]       tb_reload [CCU_TB_N];
	logic [CCU_TB_N-1:0] tb_tick;
	logic [CCU_TB_N-1:0] tb_ovf;
	logic [CCU_TB_N-1:0] tb_wr;
	logic [CCU_TB_N-1:0] tb_upd;
	logic [CCU_CFG_W-1:0] cfg [CH];
	logic [CH*TW-1:0]    vals_flat;
	logic [CH*TW-1:0]    cap_data;
	logic [CH-1:0]       cap_hit;
	logic [CH-1:0]       cmp_hit;
	logic [CCU_STAT_W-1:0] stat;
	logic [CCU_STAT_W-1:0] stat_set;
	logic [CCU_STAT_W-1:0] mask;
	logic                stat_rd;
	logic                val_wr;

	// ==========================================================
	// Pin synchronisers; edges only look at the second stage
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			pin_s1   <= '0;
			pin_s2   <= '0;
			pin_prev <= '0;
			ext_s1   <= 1'b0;
			ext_s2   <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			pin_s1   <= i_cc_pin;
			pin_s2   <= pin_s1;
			pin_prev <= pin_s2;
			ext_s1   <= i_ext_count;
			ext_s2   <= ext_s1;
			ext_prev <= ext_s2;
		end
	end

	assign pin_rise = pin_s2 & ~pin_prev;
	assign pin_fall = ~pin_s2 & pin_prev;
	assign ext_edge = ext_s2 & ~ext_prev;

	// ==========================================================
	// APB decode; no wait states, unmapped words flag an error
	assign apb_setup = i_psel & ~i_penable;
	assign wr_acc    = i_psel & i_penable & i_pwrite;
	assign rd_acc    = i_psel & i_penable & ~i_pwrite;
	assign region    = i_paddr[7:6];
	assign idx       = i_paddr[5:2];
	assign mapped    = (region == CCU_REGION_CFG) || (region == CCU_REGION_VAL) ||
	                   ((region == CCU_REGION_MISC) && (i_paddr[5:2] <= CCU_MISC_LAST));
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~mapped;

	// Control word: run bits, clock sources, staggered mode
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			tb_run    <= CCU_RUN_RST;
			tb_sel[0] <= CCU_SEL_RST;
			tb_sel[1] <= CCU_SEL_RST;
			stagger   <= 1'b0;
		end else if (wr_acc && i_paddr == CCU_ADDR_CTRL) begin
			tb_run    <= i_pwdata[CCU_CTRL_RUN_LSB +: CCU_TB_N];
			tb_sel[0] <= i_pwdata[CCU_CTRL_SEL_A_LSB +: CCU_SEL_W];
			tb_sel[1] <= i_pwdata[CCU_CTRL_SEL_B_LSB +: CCU_SEL_W];
			stagger   <= i_pwdata[CCU_CTRL_STAGGER];
		end
	end

	// ==========================================================
	// Shared prescaler and stagger slot counter
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			pre  <= '0;
			slot <= '0;
		end else begin
			pre  <= pre + 1'b1;
			slot <= slot + 1'b1;
		end
	end

	// ==========================================================
	// Time bases
	for (genvar t = 0; t < CCU_TB_N; t++) begin : g_tb
		localparam logic [7:0] OFF_RL = (t == 0) ? CCU_ADDR_RELOAD_A : CCU_ADDR_RELOAD_B;
		localparam logic [7:0] OFF_TM = (t == 0) ? CCU_ADDR_TIMER_A : CCU_ADDR_TIMER_B;
		logic [CCU_PRE_W-1:0] pre_mask;
		logic                 src;

		// Clock source pick; code 7 is the count pin for the first base only
		always_comb begin
			pre_mask = ~({CCU_PRE_W{1'b1}} << tb_sel[t]);
			case (tb_sel[t])
				CCU_SEL_NEIGHBOUR: src = i_neighbour_timer_six_ovf;
				CCU_SEL_EXT:       src = (t == 0) ? ext_edge : i_neighbour_timer_six_ovf;
				default:           src = ((pre & pre_mask) == pre_mask);
			endcase
		end

		assign tb_tick[t] = tb_run[t] & src;
		assign tb_wr[t]   = wr_acc && (i_paddr == OFF_TM);
		assign tb_ovf[t]  = tb_tick[t] & (tb_val[t] == {TW{1'b1}}) & ~tb_wr[t];

		// Reload value
		always_ff @(posedge i_sys_clk) begin
			if (!i_rstn) begin
				tb_reload[t] <= CCU_RELOAD_RST;
			end else if (wr_acc && i_paddr == OFF_RL) begin
				tb_reload[t] <= i_pwdata[TW-1:0];
			end
		end

		// Counter: software load wins over a tick
		always_ff @(posedge i_sys_clk) begin
			if (!i_rstn) begin
				tb_val[t] <= CCU_TIMER_RST;
			end else if (tb_wr[t]) begin
				tb_val[t] <= i_pwdata[TW-1:0];
			end else if (tb_ovf[t]) begin
				tb_val[t] <= tb_reload[t];
			end else if (tb_tick[t]) begin
				tb_val[t] <= tb_val[t] + 1'b1;
			end
		end

		// Marks a fresh timer value for the comparators
		always_ff @(posedge i_sys_clk) begin
			if (!i_rstn) begin
				tb_upd[t] <= 1'b0;
			end else begin
				tb_upd[t] <= tb_wr[t] | tb_tick[t];
			end
		end
	end

	// ==========================================================
	// Channels
	for (genvar n = 0; n < CH; n++) begin : g_ch
		ccu_func_t     func;
		logic          tb;
		logic [TW-1:0] tval;
		logic          slot_ok;
		logic          check;
		logic          pending;
		logic          fired;
		logic          spent;
		logic          once;
		logic          cfg_wr;
		logic          partner;
		logic          toggle;

		assign cfg_wr  = wr_acc && region == CCU_REGION_CFG && idx == IW'(n);
		assign func    = ccu_func_t'(cfg[n][CCU_CFG_FUNC_LSB +: 3]);
		assign tb      = cfg[n][CCU_CFG_TB];
		assign tval    = tb_val[tb];
		assign once    = (func == CCU_CMP_M2) || (func == CCU_CMP_M3);
		// Staggered mode visits one channel in eight per cycle
		assign slot_ok = ~stagger | (slot == CCU_SLOT_W'(n % CCU_STAGGER_SLOTS));
		assign check   = slot_ok & (pending | tb_upd[tb]);
		assign cap_data[n*TW +: TW] = tval;

		// Channel configuration
		always_ff @(posedge i_sys_clk) begin
			if (!i_rstn) begin
				cfg[n] <= CCU_CFG_RST;
			end else if (cfg_wr) begin
				cfg[n] <= i_pwdata[CCU_CFG_W-1:0];
			end
		end

		// Timer moved but channel not yet compared (waits for its slot)
		always_ff @(posedge i_sys_clk) begin
			if (!i_rstn) begin
				pending <= 1'b0;
			end else begin
				pending <= check ? 1'b0 : (pending | tb_upd[tb]);
			end
		end

		// Capture on the chosen edge
		always_comb begin
			case (func)
				CCU_CAP_RISE: cap_hit[n] = pin_rise[n];
				CCU_CAP_FALL: cap_hit[n] = pin_fall[n];
				CCU_CAP_BOTH: cap_hit[n] = pin_rise[n] | pin_fall[n];
				default:      cap_hit[n] = 1'b0;
			endcase
		end

		// Compare once per fresh timer value; an equal count hits unless spent or locked in modes 2 and 3
		assign cmp_hit[n] = func[2] & check & (vals_flat[n*TW +: TW] == tval) &
		                    ~spent & ~(once & fired);

		// Period lock for modes 2 and 3; a match beats a same-cycle overflow
		always_ff @(posedge i_sys_clk) begin
			if (!i_rstn) begin
				fired <= 1'b0;
			end else if (cfg_wr) begin
				fired <= 1'b0;
			end else begin
				fired <= (fired & ~tb_ovf[tb]) | (once & cmp_hit[n]);
			end
		end

		// Single event: spent after first match until reconfigured
		always_ff @(posedge i_sys_clk) begin
			if (!i_rstn) begin
				spent <= 1'b0;
			end else if (cfg_wr) begin
				spent <= 1'b0;
			end else if (cmp_hit[n] && cfg[n][CCU_CFG_SINGLE]) begin
				spent <= 1'b1;
			end
		end

		// Lower half channels can borrow the upper partner's matches
		if (n < CH / 2) begin : g_pair
			assign partner = cfg[n][CCU_CFG_DOUBLE] & (func == CCU_CMP_M1) & cmp_hit[n + CH / 2];
		end else begin : g_nopair
			assign partner = 1'b0;
		end

		// Two matches in one cycle cancel out, as two toggles would
		assign toggle = ((func == CCU_CMP_M1) & cmp_hit[n]) ^ partner;

		// Output pin state
		always_ff @(posedge i_sys_clk) begin
			if (!i_rstn) begin
				o_cc_pin[n] <= 1'b0;
			end else if (func == CCU_CMP_M3 && cmp_hit[n]) begin
				o_cc_pin[n] <= 1'b1;
			end else if (func == CCU_CMP_M3 && tb_ovf[tb]) begin
				o_cc_pin[n] <= 1'b0;
			end else if (toggle) begin
				o_cc_pin[n] <= ~o_cc_pin[n];
			end
		end

		// Pin driven only in pin-active compare modes
		always_ff @(posedge i_sys_clk) begin
			if (!i_rstn) begin
				o_cc_pin_oe[n] <= 1'b0;
			end else begin
				o_cc_pin_oe[n] <= (func == CCU_CMP_M1) || (func == CCU_CMP_M3);
			end
		end
	end

	// ==========================================================
	// Value array
	assign val_wr = wr_acc && region == CCU_REGION_VAL;

	ccu_cc_store #(
		.CH (CH),
		.TW (TW),
		.IW (IW)
	) u_store (
		.i_sys_clk  (i_sys_clk),
		.i_rstn     (i_rstn),
		.i_wr_en    (val_wr),
		.i_wr_idx   (idx),
		.i_wr_data  (i_pwdata[TW-1:0]),
		.i_cap      (cap_hit),
		.i_cap_data (cap_data),
		.o_vals     (vals_flat)
	);

	// ==========================================================
	// Interrupts: sticky status, read clears only bits returned
	assign stat_set = {tb_ovf, cap_hit | cmp_hit};
	assign stat_rd  = rd_acc && i_paddr == CCU_ADDR_STAT;

	// New events win over the read clear
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			stat <= '0;
		end else if (stat_rd) begin
			stat <= (stat & ~o_prdata[CCU_STAT_W-1:0]) | stat_set;
		end else begin
			stat <= stat | stat_set;
		end
	end

	// Interrupt mask
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			mask <= CCU_MASK_RST;
		end else if (wr_acc && i_paddr == CCU_ADDR_MASK) begin
			mask <= i_pwdata[CCU_STAT_W-1:0];
		end
	end

	assign o_irq = |(stat & mask);

	// ==========================================================
	// Read data, latched in the setup cycle
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_prdata <= '0;
		end else if (apb_setup && !i_pwrite) begin
			case (region)
				CCU_REGION_CFG: o_prdata <= 32'(cfg[idx]);
				CCU_REGION_VAL: o_prdata <= 32'(vals_flat[idx*TW +: TW]);
				CCU_REGION_MISC: begin
					case (i_paddr)
						CCU_ADDR_CTRL:     o_prdata <= 32'({stagger, tb_sel[1], tb_sel[0], tb_run});
						CCU_ADDR_RELOAD_A: o_prdata <= 32'(tb_reload[0]);
						CCU_ADDR_RELOAD_B: o_prdata <= 32'(tb_reload[1]);
						CCU_ADDR_TIMER_A:  o_prdata <= 32'(tb_val[0]);
						CCU_ADDR_TIMER_B:  o_prdata <= 32'(tb_val[1]);
						CCU_ADDR_STAT:     o_prdata <= 32'(stat);
						CCU_ADDR_MASK:     o_prdata <= 32'(mask);
						CCU_ADDR_PINS:     o_prdata <= {o_cc_pin, pin_s2};
						default:           o_prdata <= '0;
					endcase
				end
				default: o_prdata <= '0;
			endcase
		end
	end
endmodule : ccu_unit_two

// file: verif/ccu_pin_model.sv
`timescale 1ns/1ps
// ==========================================================
// Far side of the channel pins, with an optional lag on level changes
module ccu_pin_model (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_req,
	input  wire logic [3:0]  i_lag,
	input  wire logic [15:0] i_dut_out,
	input  wire logic [15:0] i_dut_oe,
	output logic      [15:0] o_pin
);
	logic [15:0] level = 16'h0000;
	logic [3:0]  cnt   = 4'h0;

	// A slow source holds its old level for i_lag cycles first
	always_ff @(posedge i_clk) begin
		if (i_req == level) begin
			cnt <= 4'h0;
		end else if (cnt >= i_lag) begin
			level <= i_req;
			cnt   <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end

	// Wire level: the unit wins where it drives, the source elsewhere
	assign o_pin = (i_dut_oe & i_dut_out) | (~i_dut_oe & level);
endmodule : ccu_pin_model

// file: verif/ccu_sva.sv
`timescale 1ns/1ps
// ==========================================================
// Port-level checks of the capture/compare unit
module ccu_sva import ccu_pkg::*; #(
	parameter int CH = CCU_CH,
	parameter int TW = CCU_TW
) (
	input wire logic              i_sys_clk,
	input wire logic              i_rstn,
	input wire logic              i_psel,
	input wire logic              i_penable,
	input wire logic              i_pwrite,
	input wire logic [CCU_AW-1:0] i_paddr,
	input wire logic [31:0]       i_pwdata,
	input wire logic [31:0]       o_prdata,
	input wire logic              o_pready,
	input wire logic              o_pslverr,
	input wire logic [CH-1:0]     i_cc_pin,
	input wire logic [CH-1:0]     o_cc_pin,
	input wire logic [CH-1:0]     o_cc_pin_oe,
	input wire logic              i_ext_count,
	input wire logic              i_neighbour_timer_six_ovf,
	input wire logic              o_irq
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	logic                  acc;
	logic                  unmapped;
	logic [CCU_STAT_W-1:0] mask_sh;

	// ==========================================================
	// Helper logic
	assign acc      = i_psel && i_penable;
	assign unmapped = (i_paddr[7:6] == 2'h3) || (i_paddr[7:6] == CCU_REGION_MISC && i_paddr[5:2] > CCU_MISC_LAST);
	// Mask shadow taken from bus writes, so the irq gate can be judged
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			mask_sh <= CCU_MASK_RST;
		end else if (acc && i_pwrite && i_paddr == CCU_ADDR_MASK) begin
			mask_sh <= i_pwdata[CCU_STAT_W-1:0];
		end
	end

	// ==========================================================
	// Assertions
	property p_rst_quiet;
		$rose(i_rstn) |-> o_cc_pin == '0 && o_cc_pin_oe == '0 && !o_irq;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");
	property p_irq_mask;
		o_irq |-> mask_sh != '0;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq with all sources masked");
	// Oe settles two edges after a config write; the next write is too late to mask it
	property p_oe_cfg;
		logic [3:0] n;
		logic       e;
		(acc && i_pwrite && i_paddr[7:6] == CCU_REGION_CFG, n = i_paddr[5:2],
			e = (i_pwdata[3:1] == 3'h5) || (i_pwdata[3:1] == 3'h7)) |-> ##2 o_cc_pin_oe[n] == e;
	endproperty
	a_oe_cfg: assert property (p_oe_cfg) else $error("pin enable does not follow mode");
	property p_pins_read;
		acc && !i_pwrite && i_paddr == CCU_ADDR_PINS |-> o_prdata[CCU_PINS_OUT_LSB +: CH] == $past(o_cc_pin);
	endproperty
	a_pins_read: assert property (p_pins_read) else $error("pin readback differs");
	property p_pready;
		i_psel |-> o_pready;
	endproperty
	a_pready: assert property (p_pready) else $error("wait state inserted");
	property p_err_only_acc;
		o_pslverr |-> acc;
	endproperty
	a_err_only_acc: assert property (p_err_only_acc) else $error("error outside access");
	property p_err_unmapped;
		acc && unmapped |-> o_pslverr;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access accepted");
	property p_no_err_mapped;
		acc && i_paddr[1:0] == 2'h0 && !unmapped |-> !o_pslverr;
	endproperty
	a_no_err_mapped: assert property (p_no_err_mapped) else $error("mapped access refused");
	property p_unmapped_zero;
		acc && !i_pwrite && unmapped |-> o_prdata == '0;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
endmodule : ccu_sva

bind ccu_unit_two ccu_sva #(.CH(CH), .TW(TW)) sva_u (
	.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .i_cc_pin(i_cc_pin), .o_cc_pin(o_cc_pin),
	.o_cc_pin_oe(o_cc_pin_oe), .i_ext_count(i_ext_count),
	.i_neighbour_timer_six_ovf(i_neighbour_timer_six_ovf), .o_irq(o_irq)
);

// file: verif/testbench.sv
`timescale 1ns/1ps
// ==========================================================
// Register-level bench for the capture/compare unit
module testbench import ccu_pkg::*;;
	// Channel setup: value and config for each channel
	localparam logic [31:0] CFG [16] = '{32'h02, 32'h04, 32'h06, 32'h03, 32'h1a, 32'h08, 32'h0c, 32'h0e,
		32'h28, 32'h00, 32'h00, 32'h00, 32'h08, 32'h00, 32'h00, 32'h00};
	localparam logic [31:0] CMP [16] = '{32'h00, 32'h00, 32'h00, 32'h00, 32'h10, 32'h10, 32'h10, 32'h10,
		32'h10, 32'h00, 32'h00, 32'h00, 32'h20, 32'h00, 32'h00, 32'h00};
	localparam logic [7:0] RST_ADDR [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h40, 8'h80};

	logic        sys_clk   = 1'b0;
	logic        rstn      = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] pin_in;
	logic [15:0] pin_out;
	logic [15:0] pin_oe;
	logic [15:0] pin_req   = 16'h0000;
	logic [3:0]  lag       = 4'h0;
	logic        ext_count = 1'b0;
	logic        nb_ovf    = 1'b0;
	logic        irq;
	int          error_cnt = 0;
	int          tests_run = 0;

	ccu_unit_two dut_u (
		.i_sys_clk(sys_clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_cc_pin(pin_in), .o_cc_pin(pin_out), .o_cc_pin_oe(pin_oe), .i_ext_count(ext_count),
		.i_neighbour_timer_six_ovf(nb_ovf), .o_irq(irq)
	);
	ccu_pin_model pins_u (
		.i_clk(sys_clk), .i_req(pin_req), .i_lag(lag), .i_dut_out(pin_out), .i_dut_oe(pin_oe), .o_pin(pin_in)
	);

	// Free-running system clock
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// Bench tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run
	// One APB transfer; an idle edge first so psel is never assigned twice at once
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		@(posedge sys_clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			error_cnt++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		xfer(1'b0, a, 32'h0, r, e);
		check(r, exp);
	endtask : rd_chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task automatic nb_pulse();
		@(posedge sys_clk);
		nb_ovf <= 1'b1;
		@(posedge sys_clk);
		nb_ovf <= 1'b0;
	endtask : nb_pulse

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] r;
		logic        e;
		cyc(6);
		rstn <= 1'b1;
		foreach (RST_ADDR[i]) rd_chk(RST_ADDR[i], 32'h0);
		xfer(1'b0, 8'h20, 32'h0, r, e);
		check({31'h0, e}, 32'h1);
		check(r, 32'h0);
		xfer(1'b1, 8'hc0, 32'h1, r, e);
		check({31'h0, e}, 32'h1);
		// Capture on both time bases, all edge kinds, slow and prompt pins
		wr(CCU_ADDR_RELOAD_A, 32'h1234);
		wr(CCU_ADDR_TIMER_A, 32'hbeef);
		wr(CCU_ADDR_TIMER_B, 32'h5555);
		rd_chk(CCU_ADDR_RELOAD_A, 32'h1234);
		rd_chk(CCU_ADDR_TIMER_A, 32'hbeef);
		for (int i = 0; i < 16; i++) begin
			wr(8'h80 + 8'(4 * i), CMP[i]);
			wr(8'h40 + 8'(4 * i), CFG[i]);
		end
		cyc(2);
		check({16'h0, pin_oe}, 32'h0090);
		pin_req <= 16'h000f;
		cyc(8);
		rd_chk(CCU_ADDR_STAT, 32'h000d);
		rd_chk(8'h80, 32'hbeef);
		rd_chk(8'h84, 32'h0);
		rd_chk(8'h88, 32'hbeef);
		rd_chk(8'h8c, 32'h5555);
		wr(CCU_ADDR_TIMER_A, 32'h0101);
		lag     <= 4'h3;
		pin_req <= 16'h0000;
		cyc(12);
		check({31'h0, irq}, 32'h0);
		wr(CCU_ADDR_MASK, 32'h2);
		cyc(2);
		check({31'h0, irq}, 32'h1);
		rd_chk(CCU_ADDR_STAT, 32'h0006);
		cyc(2);
		check({31'h0, irq}, 32'h0);
		rd_chk(8'h84, 32'h0101);
		rd_chk(8'h88, 32'h0101);
		// Compare: each mode, repeated match in one period, pair and overflow
		wr(CCU_ADDR_TIMER_A, 32'h0010);
		cyc(4);
		rd_chk(CCU_ADDR_PINS, 32'h00900090);
		rd_chk(CCU_ADDR_STAT, 32'h01f0);
		wr(CCU_ADDR_TIMER_A, 32'h0010);
		cyc(4);
		check({16'h0, pin_out}, 32'h0080);
		rd_chk(CCU_ADDR_STAT, 32'h0030);
		wr(CCU_ADDR_TIMER_A, 32'h0020);
		cyc(4);
		check({16'h0, pin_out}, 32'h0090);
		rd_chk(CCU_ADDR_STAT, 32'h1000);
		wr(CCU_ADDR_TIMER_A, 32'hffff);
		wr(CCU_ADDR_CTRL, 32'h19);
		nb_pulse();
		cyc(4);
		wr(CCU_ADDR_CTRL, 32'h0);
		check({16'h0, pin_out}, 32'h0010);
		rd_chk(CCU_ADDR_TIMER_A, 32'h1234);
		rd_chk(CCU_ADDR_STAT, 32'h10000);
		wr(CCU_ADDR_TIMER_A, 32'h0010);
		cyc(4);
		check({16'h0, pin_out}, 32'h0080);
		rd_chk(CCU_ADDR_STAT, 32'h00f0);
		// External count on A, neighbour overflow on B
		wr(CCU_ADDR_TIMER_A, 32'h0100);
		wr(CCU_ADDR_CTRL, 32'h1d);
		repeat (3) begin
			ext_count <= 1'b1;
			cyc(3);
			ext_count <= 1'b0;
			cyc(3);
		end
		wr(CCU_ADDR_CTRL, 32'h0);
		rd_chk(CCU_ADDR_TIMER_A, 32'h0103);
		wr(CCU_ADDR_CTRL, 32'hc2);
		nb_pulse();
		nb_pulse();
		cyc(2);
		wr(CCU_ADDR_CTRL, 32'h0);
		rd_chk(CCU_ADDR_TIMER_B, 32'h5557);
		// B on sysclk/4 for 12 edges gives 3 ticks whatever the prescaler phase
		wr(CCU_ADDR_CTRL, 32'h42);
		cyc(9);
		wr(CCU_ADDR_CTRL, 32'h100);
		rd_chk(CCU_ADDR_TIMER_B, 32'h555a);
		rd_chk(CCU_ADDR_CTRL, 32'h100);
		// Staggered compare still lands within eight cycles
		wr(CCU_ADDR_TIMER_A, 32'h0010);
		cyc(10);
		check({16'h0, pin_out}, 32'h0090);
		rd_chk(CCU_ADDR_STAT, 32'h0030);
		cyc(4);
		complete_run();
	end
endmodule : testbench
